// File: shared/hsp_pkg.sv
package hsp_pkg;
   // Table ports as seen on the link (sequence, line type, pattern, value)
   localparam logic [7:0] SEQ_PORT   = 8'hd0;
   localparam logic [7:0] LTYPE_PORT = 8'hd1;
   localparam logic [7:0] PAT_PORT   = 8'hd2;
   localparam logic [7:0] VAL_PORT   = 8'hd3;
   // Table sizes in bytes
   localparam int SEQ_BYTES = 32;   // 16 entries of two bytes
   localparam int LT_BYTES  = 60;   // 15 entries of four bytes
   localparam int PAT_BYTES = 56;   // 7 entries of four pairs
   localparam int VAL_BYTES = 16;   // 8 entries of two bytes
   // Reduced gain 0.69 as a fraction of 256
   localparam logic [7:0] GAIN_NUM = 8'hb1;
   localparam logic [9:0] PIX_MAX  = 10'h3ff;
   // Controller registers (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_RASTER = 8'h04;
   localparam logic [7:0] REG_TRIG   = 8'h08;
   localparam logic [7:0] REG_TBL_WR = 8'h0c;
   localparam logic [7:0] REG_TBL_RD = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   // Control bit positions
   localparam int CTRL_INSERT = 0;
   localparam int CTRL_GAIN   = 1;
   localparam int CTRL_HDMODE = 2;
   localparam int CTRL_YCCIN  = 3;
   localparam int CTRL_RGBOUT = 4;
   localparam int CTRL_AUTO   = 5;
   localparam int CTRL_SENSE  = 6;
   localparam int CTRL_W      = 7;
   localparam logic [6:0] CTRL_RST = 7'h00;
   // Table access fields in REG_TBL_WR / REG_TBL_RD
   localparam int TBL_SEL_LSB = 8;
   localparam int TBL_START   = 16;
   localparam int TBL_VALID   = 8;
   // Raster fields: width low, height high
   localparam int RASTER_HI = 16;
   localparam logic [11:0] RASTER_RST = 12'h000;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : hsp_pkg

// File: shared/hsp_link_if.sv
`timescale 1ns/1ps
interface hsp_link_if;
   logic        tblWr;      // Table byte write pulse
   logic        tblRd;      // Table byte read pulse
   logic        tblStart;   // Byte is an entry pointer
   logic [7:0]  tblSel;     // Table port
   logic [7:0]  tblWrData;  // Written byte
   logic [7:0]  tblRdData;  // Read byte
   logic        tblRdValid; // Read byte ready pulse
   logic [6:0]  ctrl;       // Mode bits
   logic [11:0] rasterW;    // Raster width
   logic [11:0] rasterH;    // Raster height
   logic [11:0] trigX;      // Trigger column
   logic [11:0] trigY;      // Trigger row
   logic        pixEn;      // Incoming pixel clock enable
   logic [9:0]  pixR;       // Pixel data from cursor stage
   logic [9:0]  pixG;
   logic [9:0]  pixB;
   logic        loadFlag;   // Load seen in sense window
   logic        fmtRgb;     // RGB output in effect
   logic        trig;       // Raster trigger pulse
   modport device (input tblWr, tblRd, tblStart, tblSel, tblWrData, ctrl,
      rasterW, rasterH, trigX, trigY, pixEn, pixR, pixG, pixB,
      output tblRdData, tblRdValid, loadFlag, fmtRgb, trig);
   modport host (output tblWr, tblRd, tblStart, tblSel, tblWrData, ctrl,
      rasterW, rasterH, trigX, trigY, pixEn, pixR, pixG, pixB,
      input tblRdData, tblRdValid, loadFlag, fmtRgb, trig);
endinterface : hsp_link_if

// File: rtl/hsp_device.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hsp_device (
   input  wire logic       clk,
   input  wire logic       rst_n,
   hsp_link_if.device      lnk,
   input  wire logic [2:0] loadSense,
   output logic [9:0]      dacR,
   output logic [9:0]      dacG,
   output logic [9:0]      dacB,
   output logic            hd_horiz_composite_sync_out,
   output logic            hd_vert_sync_out,
   output logic            load_detect_irq_pin
);
   typedef struct packed {
      logic [31:0][7:0] seqB;    // Line sequence table
      logic [59:0][7:0] ltB;     // Line type table
      logic [55:0][7:0] patB;    // Pattern table
      logic [15:0][7:0] valB;    // Value table
      logic [5:0]  ptr;          // Table byte pointer
      logic [7:0]  rdData;
      logic        rdValid;
      logic [3:0]  seqIdx;       // Current sequence entry
      logic [9:0]  lineCnt;      // Lines done in this run
      logic [2:0]  slot;         // Slot within line type
      logic [1:0]  pair;         // Pair within pattern
      logic [11:0] durCnt;       // Cycles into this pair
      logic [11:0] xCnt;
      logic [11:0] yCnt;
      logic        trig;
      logic [9:0]  prevLvl;      // Last inserted level
      logic [9:0]  dacR, dacG, dacB;
      logic        hs, vs, loadFlag, irq, fmtRgb;
   } hsp_dev_s;

   hsp_dev_s s, next_s;

   // Nibble of line type t at slot k; zero when type unused
   function automatic logic [3:0] nibAt(input logic [59:0][7:0] lt,
                                        input logic [3:0] t,
                                        input logic [2:0] k);
      logic [7:0] b;
      b = 8'h00;
      if (t != 4'h0) begin
         b = lt[6'({t - 4'h1, k[2:1]})];
      end
      nibAt = k[0] ? b[7:4] : b[3:0];
   endfunction : nibAt

   // Pair bytes of pattern p (1..7), pair q
   function automatic logic [15:0] pairAt(input logic [55:0][7:0] pt,
                                          input logic [3:0] p,
                                          input logic [1:0] q);
      logic [5:0] a;
      a = 6'h00;
      pairAt = 16'h0000;
      if (p != 4'h0 && p[3] == 1'b0) begin
         a = {p[2:0] - 3'h1, q, 1'b0};
         pairAt = {pt[a + 6'h01], pt[a]};
      end
   endfunction : pairAt

   // Lookup, sequencing and pixel path
   always_comb begin
      logic [7:0]  seqHi, seqLo, nHi, lvlByte;
      logic [9:0]  seqCount, ins10, filt, sr, sg, sb;
      logic [3:0]  typ, pat, lvl;
      logic [15:0] pr;
      logic [11:0] dur;
      logic [1:0]  flags;
      logic        active, lastPair, lastSlot, lastLine;
      logic [10:0] fsum;
      logic [5:0]  base;
      next_s = s;
      next_s.rdValid = 1'b0;
      next_s.trig = 1'b0;
      // low byte count, high byte type and count MSBs
      seqLo = s.seqB[{s.seqIdx, 1'b0}];
      seqHi = s.seqB[{s.seqIdx, 1'b1}];
      typ = seqHi[7:4];
      seqCount = {seqHi[1:0], seqLo};
      nHi = s.seqB[{s.seqIdx + 4'h1, 1'b1}];
      pat = nibAt(s.ltB, typ, s.slot);
      pr = pairAt(s.patB, pat, s.pair);
      dur = {pr[11:8], pr[7:0]};
      lvl = pr[15:12];
      active = typ != 4'h0 && pat != 4'h0 && !pat[3];
      lastPair = s.pair == 2'h3 ||
                 pairAt(s.patB, pat, s.pair + 2'h1) == 16'h0000;
      lastSlot = s.slot == 3'h7 ||
                 nibAt(s.ltB, typ, s.slot + 3'h1) == 4'h0 ||
                 nibAt(s.ltB, typ, s.slot + 3'h1) > 4'h7;
      // A zero count still plays one line
      lastLine = s.lineCnt + 10'h001 >= seqCount;
      lvlByte = s.valB[{lvl[2:0], 1'b0}];
      flags = s.valB[{lvl[2:0], 1'b1}][1:0];
      ins10 = (active && lnk.ctrl[hsp_pkg::CTRL_INSERT]) ?
              {lvlByte, 2'b00} : 10'h000;
      // Two-tap average softens steps of the inserted level
      fsum = {1'b0, s.prevLvl} + {1'b0, ins10};
      filt = fsum[10:1];
      // Scaled pixels, used only when the converters load
      sr = scale(lnk.pixR);
      sg = scale(lnk.pixG);
      sb = scale(lnk.pixB);
      base = lnk.tblWrData[5:0];
      // Table port: first byte is an entry pointer, then data
      if (lnk.tblWr && lnk.tblStart) begin
         case (lnk.tblSel)
            hsp_pkg::SEQ_PORT:   next_s.ptr = {base[4:0], 1'b0};
            hsp_pkg::LTYPE_PORT: next_s.ptr = {base[3:0], 2'b00};
            hsp_pkg::PAT_PORT:   next_s.ptr = {base[2:0], 3'b000};
            hsp_pkg::VAL_PORT:   next_s.ptr = {base[4:0], 1'b0};
            default:             next_s.ptr = 6'h00;
         endcase
      end else if (lnk.tblWr) begin
         // Out-of-range bytes are dropped, pointer still advances
         case (lnk.tblSel)
            hsp_pkg::SEQ_PORT: if (s.ptr < 6'(hsp_pkg::SEQ_BYTES)) begin
               next_s.seqB[s.ptr[4:0]] = lnk.tblWrData;
            end
            hsp_pkg::LTYPE_PORT: if (s.ptr < 6'(hsp_pkg::LT_BYTES)) begin
               next_s.ltB[s.ptr] = lnk.tblWrData;
            end
            hsp_pkg::PAT_PORT: if (s.ptr < 6'(hsp_pkg::PAT_BYTES)) begin
               next_s.patB[s.ptr] = lnk.tblWrData;
            end
            hsp_pkg::VAL_PORT: if (s.ptr < 6'(hsp_pkg::VAL_BYTES)) begin
               next_s.valB[s.ptr[3:0]] = lnk.tblWrData;
            end
            default: ;
         endcase
         next_s.ptr = s.ptr + 6'h01;
      end else if (lnk.tblRd) begin
         // Readback shares the pointer with writes
         case (lnk.tblSel)
            hsp_pkg::SEQ_PORT:   next_s.rdData = s.seqB[s.ptr[4:0]];
            hsp_pkg::LTYPE_PORT: next_s.rdData = s.ltB[s.ptr];
            hsp_pkg::PAT_PORT:   next_s.rdData = s.patB[s.ptr];
            hsp_pkg::VAL_PORT:   next_s.rdData = s.valB[s.ptr[3:0]];
            default:             next_s.rdData = 8'h00;
         endcase
         next_s.rdValid = 1'b1;
         next_s.ptr = s.ptr + 6'h01;
      end
      // Sync engine steps once per incoming pixel
      if (lnk.pixEn) begin
         if (!active) begin
            // Empty tables: wait at the first entry
            next_s.seqIdx = 4'h0;
            next_s.lineCnt = 10'h000;
            next_s.slot = 3'h0;
            next_s.pair = 2'h0;
            next_s.durCnt = 12'h000;
         end else if (s.durCnt < dur) begin
            next_s.durCnt = s.durCnt + 12'h001;
         end else begin
            next_s.durCnt = 12'h000;
            if (!lastPair) begin
               next_s.pair = s.pair + 2'h1;
            end else if (!lastSlot) begin
               next_s.pair = 2'h0;
               next_s.slot = s.slot + 3'h1;
            end else begin
               next_s.pair = 2'h0;
               next_s.slot = 3'h0;
               if (!lastLine) begin
                  next_s.lineCnt = s.lineCnt + 10'h001;
               end else begin
                  next_s.lineCnt = 10'h000;
                  // wrap after entry 15 or when the next entry has type zero
                  if (s.seqIdx == 4'hf || nHi[7:4] == 4'h0) begin
                     next_s.seqIdx = 4'h0;
                  end else begin
                     next_s.seqIdx = s.seqIdx + 4'h1;
                  end
               end
            end
         end
         // Raster position counters
         if (s.xCnt + 12'h001 >= lnk.rasterW) begin
            next_s.xCnt = 12'h000;
            next_s.yCnt = (s.yCnt + 12'h001 >= lnk.rasterH) ?
                          12'h000 : s.yCnt + 12'h001;
         end else begin
            next_s.xCnt = s.xCnt + 12'h001;
         end
         // Trigger wins over the step above
         if (s.xCnt == lnk.trigX && s.yCnt == lnk.trigY) begin
            next_s.trig = 1'b1;
            next_s.seqIdx = 4'h0;
            next_s.lineCnt = 10'h000;
            next_s.slot = 3'h0;
            next_s.pair = 2'h0;
            next_s.durCnt = 12'h000;
         end
         next_s.hs = active & flags[0];
         next_s.vs = active & flags[1];
         // Converters load only on pixel enables in HD mode
         if (lnk.ctrl[hsp_pkg::CTRL_HDMODE]) begin
            next_s.prevLvl = ins10;
            next_s.dacG = addSat(sg, filt);
            // green-only insert leaves red and blue clean
            next_s.dacR = lvl[3] ? sr : addSat(sr, filt);
            next_s.dacB = lvl[3] ? sb : addSat(sb, filt);
         end
      end
      // no colour matrix, so RGB needs RGB input
      next_s.fmtRgb = lnk.ctrl[hsp_pkg::CTRL_RGBOUT] &
                      ~lnk.ctrl[hsp_pkg::CTRL_YCCIN];
      // flag during sense window, pin in auto mode
      if (lnk.ctrl[hsp_pkg::CTRL_SENSE]) begin
         next_s.loadFlag = |loadSense;
      end
      next_s.irq = lnk.ctrl[hsp_pkg::CTRL_AUTO] & (|loadSense);
      if (!rst_n) begin
         next_s = '0;
      end
   end

   // Gain stage: full swing or reduced for sync headroom
   function automatic logic [9:0] scale(input logic [9:0] p);
      logic [17:0] prod;
      prod = p * hsp_pkg::GAIN_NUM;
      scale = lnk.ctrl[hsp_pkg::CTRL_GAIN] ? prod[17:8] : p;
   endfunction : scale

   // Saturating add keeps sync tips from wrapping
   function automatic logic [9:0] addSat(input logic [9:0] a,
                                         input logic [9:0] b);
      logic [10:0] t;
      t = {1'b0, a} + {1'b0, b};
      addSat = t[10] ? hsp_pkg::PIX_MAX : t[9:0];
   endfunction : addSat

   // Single state register, synchronous reset folded in above
   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign lnk.tblRdData = s.rdData;
   assign lnk.tblRdValid = s.rdValid;
   assign lnk.loadFlag = s.loadFlag;
   assign lnk.fmtRgb = s.fmtRgb;
   assign lnk.trig = s.trig;
   assign dacR = s.dacR;
   assign dacG = s.dacG;
   assign dacB = s.dacB;
   assign hd_horiz_composite_sync_out = s.hs;
   assign hd_vert_sync_out = s.vs;
   assign load_detect_irq_pin = s.irq;
endmodule : hsp_device

// File: rtl/hsp_host.sv
`timescale 1ns/1ps
module hsp_host (
   input  wire logic        clk,
   input  wire logic        rst_n,
   hsp_link_if.host         lnk,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        pixEnIn,
   input  wire logic [9:0]  pixRIn,
   input  wire logic [9:0]  pixGIn,
   input  wire logic [9:0]  pixBIn
);
   typedef struct packed {
      logic [6:0]  ctrl;
      logic [11:0] rasterW, rasterH, trigX, trigY;
      logic [7:0]  awAddr;
      logic        awHeld;       // Address taken, waiting data
      logic [31:0] wData;
      logic        wHeld;        // Data taken, waiting address
      logic        awready, wready, bvalid, arready, rvalid;
      logic [1:0]  bresp, rresp;
      logic [31:0] rdata;
      logic        tblWr, tblRd, tblStart;
      logic [7:0]  tblSel, tblData, rdByte;
      logic        rdByteValid;
      logic        pixEn;
      logic [9:0]  pixR, pixG, pixB;
   } hsp_host_s;

   hsp_host_s s, next_s;

   // AXI4-Lite slave and link driver
   always_comb begin
      logic awTake, wTake;
      next_s = s;
      next_s.tblWr = 1'b0;
      next_s.tblRd = 1'b0;
      awTake = s_axi_awvalid & s.awready;
      wTake = s_axi_wvalid & s.wready;
      if (awTake) begin
         next_s.awAddr = s_axi_awaddr;
         next_s.awHeld = 1'b1;
      end
      if (wTake) begin
         next_s.wData = s_axi_wdata;
         next_s.wHeld = 1'b1;
      end
      // Commit once both halves are in and no response waits
      if (s.awHeld && s.wHeld && !s.bvalid) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = hsp_pkg::RESP_OKAY;
         case (s.awAddr)
            hsp_pkg::REG_CTRL: next_s.ctrl = s.wData[6:0];
            hsp_pkg::REG_RASTER: begin
               next_s.rasterW = s.wData[11:0];
               next_s.rasterH = s.wData[hsp_pkg::RASTER_HI +: 12];
            end
            hsp_pkg::REG_TRIG: begin
               next_s.trigX = s.wData[11:0];
               next_s.trigY = s.wData[hsp_pkg::RASTER_HI +: 12];
            end
            hsp_pkg::REG_TBL_WR: begin
               // software orders pattern before line type
               next_s.tblWr = 1'b1;
               next_s.tblData = s.wData[7:0];
               next_s.tblSel = s.wData[hsp_pkg::TBL_SEL_LSB +: 8];
               next_s.tblStart = s.wData[hsp_pkg::TBL_START];
            end
            hsp_pkg::REG_TBL_RD: begin
               // software re-points before the next write
               next_s.tblRd = 1'b1;
               next_s.tblStart = 1'b0;
               next_s.tblSel = s.wData[hsp_pkg::TBL_SEL_LSB +: 8];
               next_s.rdByteValid = 1'b0;
            end
            hsp_pkg::REG_STATUS: ;
            default: next_s.bresp = hsp_pkg::RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      next_s.awready = !next_s.awHeld && !next_s.bvalid;
      next_s.wready = !next_s.wHeld && !next_s.bvalid;
      // Read channel: one cycle to data
      if (s_axi_arvalid && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = hsp_pkg::RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            hsp_pkg::REG_CTRL: next_s.rdata[6:0] = s.ctrl;
            hsp_pkg::REG_RASTER:
               next_s.rdata = {4'h0, s.rasterH, 4'h0, s.rasterW};
            hsp_pkg::REG_TRIG:
               next_s.rdata = {4'h0, s.trigY, 4'h0, s.trigX};
            hsp_pkg::REG_TBL_WR: ;
            hsp_pkg::REG_TBL_RD:
               next_s.rdata[8:0] = {s.rdByteValid, s.rdByte};
            hsp_pkg::REG_STATUS:
               next_s.rdata[1:0] = {lnk.fmtRgb, lnk.loadFlag};
            default: next_s.rresp = hsp_pkg::RESP_SLVERR;
         endcase
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
      // Returned byte; arrival wins over the clear above
      if (lnk.tblRdValid) begin
         next_s.rdByte = lnk.tblRdData;
         next_s.rdByteValid = 1'b1;
      end
      // Pixels pass through one register stage
      next_s.pixEn = pixEnIn;
      next_s.pixR = pixRIn;
      next_s.pixG = pixGIn;
      next_s.pixB = pixBIn;
      if (!rst_n) begin
         next_s = '0;
         next_s.ctrl = hsp_pkg::CTRL_RST;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
         next_s.arready = 1'b1;
      end
   end

   // Write strobes are ignored: each register is one whole word
   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign lnk.tblWr = s.tblWr;
   assign lnk.tblRd = s.tblRd;
   assign lnk.tblStart = s.tblStart;
   assign lnk.tblSel = s.tblSel;
   assign lnk.tblWrData = s.tblData;
   assign lnk.ctrl = s.ctrl;
   assign lnk.rasterW = s.rasterW;
   assign lnk.rasterH = s.rasterH;
   assign lnk.trigX = s.trigX;
   assign lnk.trigY = s.trigY;
   assign lnk.pixEn = s.pixEn;
   assign lnk.pixR = s.pixR;
   assign lnk.pixG = s.pixG;
   assign lnk.pixB = s.pixB;
endmodule : hsp_host

// File: tb/hsp_checker.sv
`timescale 1ns/1ps
module hsp_checker (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       tblWr,
   input wire logic       tblRd,
   input wire logic       tblRdValid,
   input wire logic [6:0] ctrl,
   input wire logic       loadFlag,
   input wire logic       fmtRgb
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Each table read is answered on the next cycle
   rd_answer_a: assert property (tblRd |=> tblRdValid)
      else $error("table read not answered");
   // A read byte never appears without a request
   rd_cause_a: assert property (tblRdValid |-> $past(tblRd))
      else $error("read byte without request");
   // Read answer is a single pulse
   rd_pulse_a: assert property (tblRdValid |=> !tblRdValid)
      else $error("read answer too long");
   // One byte per write pulse, else the pointer skips
   wr_pulse_a: assert property (tblWr |=> !tblWr)
      else $error("write pulse too long");
   // Read and write share the pointer, never together
   wr_rd_excl_a: assert property (!(tblWr && tblRd))
      else $error("read and write together");
   // Colour difference input forbids RGB out
   ycc_no_rgb_a: assert property (
      ctrl[3] && $past(ctrl[3]) |-> !fmtRgb)
      else $error("RGB with colour difference input");
   // No RGB unless asked for
   rgb_off_a: assert property (
      !ctrl[4] && !$past(ctrl[4]) |-> !fmtRgb)
      else $error("RGB without request");
   // Load flag only moves inside the sense window
   load_hold_a: assert property (
      !ctrl[6] && !$past(ctrl[6]) |-> $stable(loadFlag))
      else $error("load flag moved outside window");
endmodule : hsp_checker

// File: tb/hd_sync_pattern_engine_bench.sv
`timescale 1ns/1ps
module hd_sync_pattern_engine_bench;
   logic        clk = 1'h0;        // 50 MHz clock
   logic        rst_n = 1'h0;      // Sync reset
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic        awvalid = '0, wvalid = '0, arvalid = '0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [9:0]  pix = '0, dacR, dacG, dacB;
   logic [2:0]  loadSense = '0;    // Load comparators
   logic        pe = 1'h1;         // Incoming pixel enable
   logic        hSync, vSync, irqPin;
   int          err_total = 0, n_tests = 0, c;
   // Pointer, then bytes: values, patterns before line types, sequence
   localparam logic [16:0] PROG [15] = '{'h1d300, 'h0d340, 'h0d301,
      'h0d320, 'h0d302, 'h1d200, 'h0d202, 'h0d200, 'h0d201, 'h0d210,
      'h1d100, 'h0d101, 'h1d000, 'h0d001, 'h0d010};
   localparam logic [8:0] RB [2] = '{9'h140, 9'h101};
   hsp_link_if lnk ();
   always #10 clk = ~clk;
   hsp_host hsp_host_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'h1), .pixEnIn(pe), .pixRIn(pix), .pixGIn(pix),
      .pixBIn(pix));
   hsp_device hsp_device_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
      .loadSense(loadSense), .dacR(dacR), .dacG(dacG), .dacB(dacB),
      .hd_horiz_composite_sync_out(hSync), .hd_vert_sync_out(vSync),
      .load_detect_irq_pin(irqPin));
   hsp_checker hsp_checker_inst (.clk(clk), .rst_n(rst_n),
      .tblWr(lnk.tblWr), .tblRd(lnk.tblRd), .tblRdValid(lnk.tblRdValid),
      .ctrl(lnk.ctrl), .loadFlag(lnk.loadFlag), .fmtRgb(lnk.fmtRgb));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Write: both halves offered, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic got;
      got = 1'h0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!got) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         got = bvalid;
         r = bresp;
      end
   endtask : wr
   // Read: held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a);
      logic got;
      got = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      while (!got) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
         got = rvalid;
         d = rdata;
         r = rresp;
      end
   endtask : rd
   // Verdict and end of run
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk(awready, 1);
      foreach (PROG[i]) wr(hsp_pkg::REG_TBL_WR, PROG[i]);
      // Raster matches the table totals: 5 pixels, 1 line
      wr(hsp_pkg::REG_RASTER, 32'h00010005);
      wr(hsp_pkg::REG_TRIG, 32'h0fff0fff);   // Trigger kept out of reach
      wr(hsp_pkg::REG_CTRL, 32'h05);
      // One line: 3 cycles hsync level, 2 cycles vsync level, repeat
      while (hSync) @(posedge clk);
      while (!hSync) @(posedge clk);
      for (c = 0; hSync; c++) @(posedge clk);
      chk(c, 3);
      chk(vSync, 1);
      for (c = 0; vSync; c++) @(posedge clk);
      chk(c, 2);
      chk(hSync, 1);
      // Trigger at the raster origin pulses once per line
      wr(hsp_pkg::REG_TRIG, 32'h0);
      c = 0;
      repeat (10) begin
         @(posedge clk);
         c += lnk.trig;
      end
      chk(c, 2);
      // Gain full, then reduced, insertion off
      pix <= 10'h3ff;
      wr(hsp_pkg::REG_CTRL, 32'h04);
      repeat (5) @(posedge clk);
      chk(dacR, 10'h3ff);
      wr(hsp_pkg::REG_CTRL, 32'h06);
      repeat (5) @(posedge clk);
      chk(dacG, (32'h3ff * hsp_pkg::GAIN_NUM) >> 8);
      // Converters hold while no pixel enable arrives
      pe <= 1'h0;
      pix <= 10'h000;
      repeat (5) @(posedge clk);
      chk(dacG, (32'h3ff * hsp_pkg::GAIN_NUM) >> 8);
      pe <= 1'h1;
      // Load sense with RGB out, then colour difference input
      loadSense <= 3'h2;
      wr(hsp_pkg::REG_CTRL, 32'h74);
      repeat (3) @(posedge clk);
      chk(irqPin, 1);
      rd(hsp_pkg::REG_STATUS);
      chk(d[1:0], 2'h3);
      loadSense <= 3'h0;
      wr(hsp_pkg::REG_CTRL, 32'h7c);
      repeat (3) @(posedge clk);
      chk(irqPin, 0);
      rd(hsp_pkg::REG_STATUS);
      chk(d[1:0], 2'h0);
      // Sense window closed: pin follows loads, flag holds
      wr(hsp_pkg::REG_CTRL, 32'h24);
      loadSense <= 3'h1;
      repeat (3) @(posedge clk);
      chk(irqPin, 1);
      rd(hsp_pkg::REG_STATUS);
      chk(d[1:0], 2'h0);
      // Unmapped place is refused both ways
      wr(8'h40, 32'h0);
      chk(r, hsp_pkg::RESP_SLVERR);
      rd(8'h40);
      chk(r, hsp_pkg::RESP_SLVERR);
      // Readback of value table, pointer set first
      wr(hsp_pkg::REG_TBL_WR, 32'h1d300);
      for (int i = 0; i < 2; i++) begin
         wr(hsp_pkg::REG_TBL_RD, 32'hd300);
         repeat (3) @(posedge clk);
         rd(hsp_pkg::REG_TBL_RD);
         chk(d[8:0], RB[i]);
      end
      stop_test();
   end
endmodule : hd_sync_pattern_engine_bench
